/* verilog/split_timer_pkg.sv */
package split_timer_pkg;

	// Register select codes on the peripheral bus
	localparam logic [2:0] SEL_CONTROL    = 3'h0;
	localparam logic [2:0] SEL_STATUS     = 3'h1;
	localparam logic [2:0] SEL_CNT_UPPER  = 3'h2;
	localparam logic [2:0] SEL_CNT_LOWER  = 3'h3;
	localparam logic [2:0] SEL_CMP_UPPER  = 3'h4;
	localparam logic [2:0] SEL_CMP_LOWER  = 3'h5;
	localparam logic [2:0] SEL_CLOCK_STOP = 3'h6;

	// timer_ctrl_status bit positions
	localparam int UP_OVF_BIT    = 7;
	localparam int UP_MATCH_BIT  = 6;
	localparam int UP_OVF_IE_BIT = 5;
	localparam int UP_CLR_BIT    = 4;
	localparam int LO_OVF_BIT    = 3;
	localparam int LO_MATCH_BIT  = 2;
	localparam int LO_OVF_IE_BIT = 1;
	localparam int LO_CLR_BIT    = 0;
	localparam logic [7:0] FLAG_MASK = 8'hcc;

	// timer_control bit positions
	localparam int UPPER_LEVEL_BIT = 7;
	localparam int SPLIT_BIT       = 6;
	localparam int UPPER_CKS_HI    = 5;
	localparam int UPPER_CKS_LO    = 4;
	localparam int LOWER_LEVEL_BIT = 3;
	localparam int LOWER_SRC_BIT   = 2;
	localparam int LOWER_CKS_HI    = 1;
	localparam int LOWER_CKS_LO    = 0;

	// module_clock_stop_1
	localparam int STANDBY_BIT = 2;

	// Reset values, all-ones byte and unmapped read value
	localparam logic [7:0]  STATUS_RESET  = 8'h00;
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  CKSTOP_RESET  = 8'hff;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] COMPARE_RESET = 16'hffff;
	localparam logic [7:0]  BYTE_ALL_ONES = 8'hff;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;

	// Prescaler terminal counts
	localparam logic [4:0] DIV32_LAST = 5'h1f;
	localparam logic [3:0] DIV16_LAST = 4'hf;
	localparam logic [1:0] DIV4_LAST  = 2'h3;

	// Clock select codes
	localparam logic [1:0] CKS_DIV32 = 2'h0;
	localparam logic [1:0] CKS_DIV16 = 2'h1;
	localparam logic [1:0] CKS_DIV4  = 2'h2;
	localparam logic [1:0] CKS_SUB4  = 2'h3;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] sel;
		logic [7:0] wdata;
	} cpu_req_t;

endpackage

/* verilog/split_timer.sv */
`timescale 1ns/1ps

module split_timer
	import split_timer_pkg::*;
(
	input  wire logic     clock,
	input  wire logic     rst,
	input  wire cpu_req_t cpu_req,
	output logic [7:0]    cpu_rdata,
	input  wire logic     event_input_pin,
	input  wire logic     event_edge_select,
	input  wire logic     subclock_tick,
	input  wire logic     upper_irq_ctrl_enable,
	input  wire logic     lower_irq_ctrl_enable,
	output logic          upper_toggle_pin,
	output logic          lower_toggle_pin,
	output logic          upper_irq_req,
	output logic          lower_irq_req
);

	logic [7:0] status_q, status_d;
	logic [7:0] armed_q,  armed_d;
	logic [7:0] control_q, control_d;
	logic [7:0] ckstop_q, ckstop_d;
	logic [7:0] upper_counter_q, upper_counter_d;
	logic [7:0] lower_counter_q, lower_counter_d;
	logic [7:0] upper_compare_q, upper_compare_d;
	logic [7:0] lower_compare_q, lower_compare_d;
	logic [7:0] stage_q, stage_d;
	logic [7:0] rdata_q, rdata_d;
	logic [4:0] div_q, div_d;
	logic [1:0] sub_div_q, sub_div_d;
	logic       ev_prev_q, ev_prev_d;
	logic       upin_q, upin_d;
	logic       lpin_q, lpin_d;

	logic       tick32, tick16, tick4, tick_sub;
	logic       run, split, ev_edge;
	logic       tick_l, tick_h, lo_wrap;
	logic       match16, match_l, match_h;
	logic       clr_whole, clr_l, clr_h;
	logic       ovf_l, ovf_h;
	logic       wr_status, wr_cnt_hi, wr_cnt_lo;
	logic [7:0] set_bits, clr_bits;

	function automatic logic pick_tick(input logic [1:0] cks, input logic t32,
		input logic t16, input logic t4, input logic tsub);
		logic t;
		unique case (cks)
			CKS_DIV32: t = t32;
			CKS_DIV16: t = t16;
			CKS_DIV4:  t = t4;
			CKS_SUB4:  t = tsub;
		endcase
		return t;
	endfunction

	// Byte helpers shared by both halves
	function automatic logic at_top(input logic [7:0] value);
		return value == BYTE_ALL_ONES;
	endfunction

	function automatic logic [7:0] bump(input logic [7:0] value);
		return value + 8'h01;
	endfunction

	// Request level: control enable and (match, or overflow when its enable is set)
	function automatic logic irq_level(input logic ctrl_en, input logic match_flag,
		input logic ovf_en, input logic ovf_flag);
		return ctrl_en & (match_flag | (ovf_en & ovf_flag));
	endfunction

	// Prescaler and event edge
	always_comb begin
		div_d     = div_q + 5'h01;
		sub_div_d = sub_div_q + {1'b0, subclock_tick};
		ev_prev_d = event_input_pin;
		tick32    = (div_q == DIV32_LAST);
		tick16    = (div_q[3:0] == DIV16_LAST);
		tick4     = (div_q[1:0] == DIV4_LAST);
		tick_sub  = subclock_tick & (sub_div_q == DIV4_LAST);
		// Input held one clock is seen by the previous-sample compare
		ev_edge   = event_edge_select ? (event_input_pin & ~ev_prev_q)
			: (~event_input_pin & ev_prev_q);
	end

	// Prescaler and edge sampler registers
	always_ff @(posedge clock) begin
		if (rst) begin
			div_q     <= '0;
			sub_div_q <= '0;
			ev_prev_q <= 1'b0;
		end else begin
			div_q     <= div_d;
			sub_div_q <= sub_div_d;
			ev_prev_q <= ev_prev_d;
		end
	end

	// Counting, match and overflow events
	always_comb begin
		run     = ckstop_q[STANDBY_BIT];
		split   = control_q[SPLIT_BIT];
		tick_l  = run & (control_q[LOWER_SRC_BIT]
			? pick_tick(control_q[LOWER_CKS_HI:LOWER_CKS_LO], tick32, tick16, tick4, tick_sub)
			: ev_edge);
		lo_wrap = tick_l & at_top(lower_counter_q);
		tick_h  = split
			? run & pick_tick(control_q[UPPER_CKS_HI:UPPER_CKS_LO], tick32, tick16, tick4,
				tick_sub)
			: lo_wrap;
		match16 = tick_l & ({upper_counter_q, lower_counter_q}
			== {upper_compare_q, lower_compare_q});
		match_l = tick_l & (lower_counter_q == lower_compare_q);
		match_h = split ? (tick_h & (upper_counter_q == upper_compare_q)) : match16;
		clr_whole = ~split & match16 & status_q[UP_CLR_BIT];
		clr_h     = split & match_h & status_q[UP_CLR_BIT];
		clr_l     = split & match_l & status_q[LO_CLR_BIT];
		wr_status = cpu_req.wr & (cpu_req.sel == SEL_STATUS);
		wr_cnt_hi = cpu_req.wr & (cpu_req.sel == SEL_CNT_UPPER);
		wr_cnt_lo = cpu_req.wr & (cpu_req.sel == SEL_CNT_LOWER);
		// A counter write in the same cycle cancels the overflow
		ovf_l = lo_wrap & ~clr_l & ~clr_whole & ~wr_cnt_lo;
		ovf_h = split
			? (tick_h & at_top(upper_counter_q) & ~clr_h
				& ~wr_cnt_hi)
			: (lo_wrap & at_top(upper_counter_q) & ~clr_whole
				& ~wr_cnt_lo);
		set_bits = '0;
		set_bits[UP_OVF_BIT]   = ovf_h;
		set_bits[UP_MATCH_BIT] = match_h;
		set_bits[LO_OVF_BIT]   = ovf_l;
		set_bits[LO_MATCH_BIT] = match_l;
	end

	// Register file, counters and pins
	always_comb begin
		status_d        = status_q;
		armed_d         = armed_q;
		control_d       = control_q;
		ckstop_d        = ckstop_q;
		upper_compare_d = upper_compare_q;
		lower_compare_d = lower_compare_q;
		stage_d         = stage_q;
		rdata_d         = rdata_q;
		upin_d          = upin_q;
		lpin_d          = lpin_q;
		clr_bits        = '0;

		lower_counter_d = lower_counter_q;
		if (clr_whole || clr_l) begin
			lower_counter_d = '0;
		end else if (tick_l) begin
			lower_counter_d = bump(lower_counter_q);
		end
		upper_counter_d = upper_counter_q;
		if (clr_whole || clr_h) begin
			upper_counter_d = '0;
		end else if (tick_h) begin
			upper_counter_d = bump(upper_counter_q);
		end

		if (match_h) begin
			upin_d = ~upin_q;
		end
		if (match_l) begin
			lpin_d = ~lpin_q;
		end

		if (cpu_req.rd) begin
			unique case (cpu_req.sel)
				SEL_CONTROL:    rdata_d = control_q;
				SEL_STATUS: begin
					rdata_d = status_q;
					armed_d = status_q & FLAG_MASK;
				end
				SEL_CNT_UPPER: begin
					rdata_d = upper_counter_q;
					if (!split) begin
						stage_d = lower_counter_q;
					end
				end
				SEL_CNT_LOWER:  rdata_d = split ? lower_counter_q : stage_q;
				SEL_CMP_UPPER:  rdata_d = upper_compare_q;
				SEL_CMP_LOWER:  rdata_d = lower_compare_q;
				SEL_CLOCK_STOP: rdata_d = ckstop_q;
				default:        rdata_d = UNMAPPED_READ;
			endcase
		end

		if (cpu_req.wr) begin
			unique case (cpu_req.sel)
				SEL_CONTROL: begin
					control_d = cpu_req.wdata;
					upin_d    = cpu_req.wdata[UPPER_LEVEL_BIT];
					lpin_d    = cpu_req.wdata[LOWER_LEVEL_BIT];
				end
				SEL_STATUS: begin
					clr_bits = armed_q & ~cpu_req.wdata & FLAG_MASK;
					armed_d  = armed_q & ~clr_bits;
					status_d = (cpu_req.wdata & ~FLAG_MASK)
						| (status_q & FLAG_MASK & ~clr_bits);
				end
				SEL_CNT_UPPER: begin
					if (split) begin
						upper_counter_d = cpu_req.wdata;
					end else begin
						stage_d = cpu_req.wdata;
					end
				end
				SEL_CNT_LOWER: begin
					lower_counter_d = cpu_req.wdata;
					if (!split) begin
						upper_counter_d = stage_q;
					end
				end
				SEL_CMP_UPPER: begin
					if (split) begin
						upper_compare_d = cpu_req.wdata;
					end else begin
						stage_d = cpu_req.wdata;
					end
				end
				SEL_CMP_LOWER: begin
					lower_compare_d = cpu_req.wdata;
					if (!split) begin
						upper_compare_d = stage_q;
					end
				end
				SEL_CLOCK_STOP: ckstop_d = cpu_req.wdata;
				default: begin
				end
			endcase
		end

		// Hardware set applied last so it wins over a clear
		status_d = status_d | set_bits;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			status_q        <= STATUS_RESET;
			armed_q         <= STATUS_RESET;
			control_q       <= CONTROL_RESET;
			ckstop_q        <= CKSTOP_RESET;
			upper_counter_q <= COUNT_RESET[15:8];
			lower_counter_q <= COUNT_RESET[7:0];
			upper_compare_q <= COMPARE_RESET[15:8];
			lower_compare_q <= COMPARE_RESET[7:0];
			stage_q         <= '0;
			rdata_q         <= '0;
			upin_q          <= 1'b0;
			lpin_q          <= 1'b0;
		end else begin
			status_q        <= status_d;
			armed_q         <= armed_d;
			control_q       <= control_d;
			ckstop_q        <= ckstop_d;
			upper_counter_q <= upper_counter_d;
			lower_counter_q <= lower_counter_d;
			upper_compare_q <= upper_compare_d;
			lower_compare_q <= lower_compare_d;
			stage_q         <= stage_d;
			rdata_q         <= rdata_d;
			upin_q          <= upin_d;
			lpin_q          <= lpin_d;
		end
	end

	assign cpu_rdata        = rdata_q;
	assign upper_toggle_pin = upin_q;
	assign lower_toggle_pin = lpin_q;
	assign upper_irq_req    = irq_level(upper_irq_ctrl_enable, status_q[UP_MATCH_BIT],
		status_q[UP_OVF_IE_BIT], status_q[UP_OVF_BIT]);
	assign lower_irq_req    = irq_level(lower_irq_ctrl_enable, status_q[LO_MATCH_BIT],
		status_q[LO_OVF_IE_BIT], status_q[LO_OVF_BIT]);

endmodule

/* test/split_timer_sva.sv */
`timescale 1ns/1ps
module split_timer_sva
	import split_timer_pkg::*;
(
	input wire logic       clock,
	input wire logic       rst,
	input wire cpu_req_t   cpu_req,
	input wire logic [7:0] cpu_rdata,
	input wire logic       event_input_pin,
	input wire logic       event_edge_select,
	input wire logic       subclock_tick,
	input wire logic       upper_irq_ctrl_enable,
	input wire logic       lower_irq_ctrl_enable,
	input wire logic       upper_toggle_pin,
	input wire logic       lower_toggle_pin,
	input wire logic       upper_irq_req,
	input wire logic       lower_irq_req
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	a_rdata_reset: assert property ($past(rst) |-> cpu_rdata == 8'h00)
		else $error("read data not zero after reset");
	a_pins_reset: assert property ($past(rst) |-> !upper_toggle_pin && !lower_toggle_pin)
		else $error("pin high after reset");
	a_irq_reset: assert property ($past(rst) |-> !upper_irq_req && !lower_irq_req)
		else $error("request high after reset");
	a_upper_gate: assert property (upper_irq_req |-> upper_irq_ctrl_enable)
		else $error("upper request without enable");
	a_lower_gate: assert property (lower_irq_req |-> lower_irq_ctrl_enable)
		else $error("lower request without enable");
	a_upper_level: assert property (cpu_req.wr && cpu_req.sel == SEL_CONTROL |=>
		upper_toggle_pin == $past(cpu_req.wdata[UPPER_LEVEL_BIT]))
		else $error("upper pin misses level bit");
	a_lower_level: assert property (cpu_req.wr && cpu_req.sel == SEL_CONTROL |=>
		lower_toggle_pin == $past(cpu_req.wdata[LOWER_LEVEL_BIT]))
		else $error("lower pin misses level bit");
	a_rdata_hold: assert property (!cpu_req.rd |=> $stable(cpu_rdata))
		else $error("read data changed without read");
endmodule

bind split_timer split_timer_sva sva_u (.clock, .rst, .cpu_req, .cpu_rdata, .event_input_pin,
	.event_edge_select, .subclock_tick, .upper_irq_ctrl_enable, .lower_irq_ctrl_enable,
	.upper_toggle_pin, .lower_toggle_pin, .upper_irq_req, .lower_irq_req);

/* test/event_source.sv */
`timescale 1ns/1ps
module event_source (
	input wire logic clock,
	output logic     event_input_pin
);
	initial event_input_pin = 1'b0;

	// Each level held three system clocks
	task automatic pulse();
		@(negedge clock);
		event_input_pin = 1'b1;
		repeat (3) @(negedge clock);
		event_input_pin = 1'b0;
		repeat (3) @(negedge clock);
	endtask
endmodule

/* test/split_timer_test.sv */
`timescale 1ns/1ps
module split_timer_test
	import split_timer_pkg::*;
;
	logic       clock;
	logic       rst;
	cpu_req_t   cpu_req;
	logic [7:0] cpu_rdata;
	logic       event_input_pin;
	logic       event_edge_select;
	logic       subclock_tick;
	logic       upper_irq_ctrl_enable;
	logic       lower_irq_ctrl_enable;
	logic       upper_toggle_pin;
	logic       lower_toggle_pin;
	logic       upper_irq_req;
	logic       lower_irq_req;
	int         n_errors = 0;
	int         n_compared = 0;

	split_timer dut_u (.clock, .rst, .cpu_req, .cpu_rdata, .event_input_pin,
		.event_edge_select, .subclock_tick, .upper_irq_ctrl_enable, .lower_irq_ctrl_enable,
		.upper_toggle_pin, .lower_toggle_pin, .upper_irq_req, .lower_irq_req);
	event_source ev_u (.clock, .event_input_pin);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic final_report();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		@(negedge clock);
		cpu_req = '{1'b0, 1'b1, s, d};
		@(negedge clock);
		cpu_req = '0;
	endtask

	task automatic rd(input logic [2:0] s, input logic [7:0] exp);
		@(negedge clock);
		cpu_req = '{1'b1, 1'b0, s, 8'h00};
		@(negedge clock);
		cpu_req = '0;
		chk(cpu_rdata, exp);
	endtask

	task automatic t_reset();
		rd(SEL_STATUS, 8'h00);
		rd(SEL_CONTROL, 8'h00);
		rd(SEL_CLOCK_STOP, 8'hff);
		rd(SEL_CNT_UPPER, 8'h00);
		rd(SEL_CNT_LOWER, 8'h00);
		rd(SEL_CMP_UPPER, 8'hff);
		rd(SEL_CMP_LOWER, 8'hff);
		wr(SEL_STATUS, 8'hcc);
		rd(SEL_STATUS, 8'h00);
		rd(3'h7, 8'h00);
	endtask

	task automatic t_staging();
		wr(SEL_CNT_UPPER, 8'haa);
		wr(SEL_CNT_LOWER, 8'h55);
		wr(SEL_CMP_UPPER, 8'h12);
		wr(SEL_CMP_LOWER, 8'h34);
		rd(SEL_CNT_UPPER, 8'haa);
		rd(SEL_CMP_LOWER, 8'h34);
		rd(SEL_CMP_UPPER, 8'h12);
		rd(SEL_CNT_LOWER, 8'h55);
	endtask

	task automatic t_events();
		wr(SEL_CNT_UPPER, 8'h00);
		wr(SEL_CNT_LOWER, 8'h00);
		event_edge_select = 1'b1;
		repeat (3) ev_u.pulse();
		event_edge_select = 1'b0;
		repeat (2) ev_u.pulse();
		rd(SEL_CNT_UPPER, 8'h00);
		rd(SEL_CNT_LOWER, 8'h05);
	endtask

	task automatic t_match();
		wr(SEL_CONTROL, 8'h04);
		wr(SEL_CNT_UPPER, 8'h00);
		wr(SEL_CNT_LOWER, 8'h00);
		wr(SEL_CMP_UPPER, 8'h00);
		wr(SEL_CMP_LOWER, 8'h02);
		upper_irq_ctrl_enable = 1'b1;
		repeat (140) @(negedge clock);
		chk({7'h00, upper_toggle_pin}, 8'h01);
		chk({7'h00, upper_irq_req}, 8'h01);
		wr(SEL_STATUS, 8'h00);
		rd(SEL_STATUS, 8'h44);
		wr(SEL_STATUS, 8'h00);
		rd(SEL_STATUS, 8'h00);
		chk({7'h00, upper_irq_req}, 8'h00);
	endtask

	task automatic t_split();
		wr(SEL_CMP_UPPER, 8'h80);
		wr(SEL_CMP_LOWER, 8'h40);
		wr(SEL_CONTROL, 8'hce);
		chk({6'h00, upper_toggle_pin, lower_toggle_pin}, 8'h03);
		wr(SEL_STATUS, 8'h02);
		wr(SEL_CNT_LOWER, 8'hfe);
		lower_irq_ctrl_enable = 1'b1;
		repeat (20) @(negedge clock);
		rd(SEL_STATUS, 8'h0a);
		chk({7'h00, lower_irq_req}, 8'h01);
		wr(SEL_CLOCK_STOP, 8'hfb);
		wr(SEL_CNT_LOWER, 8'h10);
		repeat (20) @(negedge clock);
		rd(SEL_CNT_LOWER, 8'h10);
	endtask

	task automatic t_clear();
		wr(SEL_CMP_LOWER, 8'h00);
		wr(SEL_STATUS, 8'h01);
		wr(SEL_CONTROL, 8'h45);
		wr(SEL_CNT_LOWER, 8'h00);
		wr(SEL_CLOCK_STOP, 8'hff);
		repeat (40) @(negedge clock);
		rd(SEL_CNT_LOWER, 8'h00);
		rd(SEL_STATUS, 8'h05);
		chk({7'h00, lower_irq_req}, 8'h01);
		wr(SEL_CONTROL, 8'h47);
		wr(SEL_STATUS, 8'h00);
		repeat (8) begin
			@(negedge clock);
			subclock_tick = 1'b1;
			@(negedge clock);
			subclock_tick = 1'b0;
		end
		rd(SEL_CNT_LOWER, 8'h02);
		chk({7'h00, lower_toggle_pin}, 8'h01);
		rd(SEL_STATUS, 8'h04);
		wr(SEL_CONTROL, 8'h06);
		wr(SEL_STATUS, 8'h00);
		wr(SEL_CNT_UPPER, 8'hff);
		wr(SEL_CNT_LOWER, 8'hfe);
		repeat (16) @(negedge clock);
		rd(SEL_STATUS, 8'h8c);
		chk({7'h00, upper_irq_req}, 8'h00);
		wr(SEL_STATUS, 8'hac);
		chk({7'h00, upper_irq_req}, 8'h01);
		wr(SEL_STATUS, 8'h10);
		wr(SEL_CMP_UPPER, 8'h00);
		wr(SEL_CMP_LOWER, 8'h00);
		wr(SEL_CNT_UPPER, 8'h00);
		wr(SEL_CNT_LOWER, 8'h00);
		repeat (12) @(negedge clock);
		rd(SEL_CNT_UPPER, 8'h00);
		rd(SEL_CNT_LOWER, 8'h00);
		rd(SEL_STATUS, 8'h54);
	endtask

	initial begin
		rst = 1'b1;
		cpu_req = '0;
		event_edge_select = 1'b1;
		subclock_tick = 1'b0;
		upper_irq_ctrl_enable = 1'b0;
		lower_irq_ctrl_enable = 1'b0;
		repeat (8) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_reset();
		t_staging();
		t_events();
		t_match();
		t_split();
		t_clear();
		final_report();
	end

	initial begin
		#50000;
		n_errors++;
		final_report();
	end
endmodule
